/* File: settings_group_map.svh */
// Register offsets, field positions and reset values of the group selector
`ifndef SETTINGS_GROUP_MAP_SVH
`define SETTINGS_GROUP_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SG_PB_CONFIG_OFFSET   8'h00
`define SG_PB_REMOTE_OFFSET   8'h04
`define SG_GROUP_CFG_OFFSET   8'h08
`define SG_GROUP_STAT_OFFSET  8'h0C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SG_PB_ENABLE_LSB      0
`define SG_PB_MAINT_LSB       8
`define SG_ALT_ONE_SELECT_INPUT_EN_BIT        0
`define SG_ALT_TWO_SELECT_INPUT_EN_BIT        1
`define SG_STAT_ACTIVE_LSB    0
`define SG_STAT_ALT_ONE_SELECT_INPUT_SEL_BIT  4
`define SG_STAT_ALT_TWO_SELECT_INPUT_SEL_BIT  5
`define SG_STAT_LOCK_BIT      6

// ----------------------------------------------------------------------
// Reset values and pushbutton count
// ----------------------------------------------------------------------
`define SG_PB_ENABLE_RESET    6'h00
`define SG_PB_MAINT_RESET     6'h3F
`define SG_ALT_EN_RESET       2'h3
`define SG_PB_COUNT           6

`endif

/* File: settings_group_pkg.sv */
// Types shared by the group selector modules
package settings_group_pkg;

  typedef enum logic [2:0] {
    GRP_PRIMARY = 3'b001,
    GRP_ALT_ONE = 3'b010,
    GRP_ALT_TWO = 3'b100
  } group_t;

  typedef enum logic [1:0] {
    AHB_IDLE   = 2'b00,
    AHB_BUSY   = 2'b01,
    AHB_NONSEQ = 2'b10,
    AHB_SEQ    = 2'b11
  } htrans_t;

endpackage : settings_group_pkg

/* File: group_if.sv */
// Signals between the register block and the group sequencer
interface group_if;
  import settings_group_pkg::*;

  logic   advance;       // Advance input level
  logic   altOneSel;     // Alternate one select level
  logic   altTwoSel;     // Alternate two select level
  logic   altOneEn;      // Alternate one enabled
  logic   altTwoEn;      // Alternate two enabled
  logic   restoreValid;  // Stored group is valid
  group_t restoreGroup;  // Stored group from non-volatile store
  group_t active;        // Active group, one-hot
  logic   saveStrobe;    // Active group changed

  modport ctrl (output advance, altOneSel, altTwoSel, altOneEn, altTwoEn,
                output restoreValid, restoreGroup,
                input  active, saveStrobe);
  modport seq  (input  advance, altOneSel, altTwoSel, altOneEn, altTwoEn,
                input  restoreValid, restoreGroup,
                output active, saveStrobe);
endinterface : group_if

/* File: group_sequencer.sv */
// Active settings group sequencer
module group_sequencer
  import settings_group_pkg::*;
(
  input wire logic clk,     // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  group_if.seq     grp      // Group control and status
);

  // --------------------------------------------------------------------
  // Next enabled group in the order primary, alt one, alt two
  // --------------------------------------------------------------------
  function automatic group_t nextGroup(input group_t cur,
                                       input logic en1,
                                       input logic en2);
    group_t n;
    n = GRP_PRIMARY;
    case (cur)
      GRP_PRIMARY: begin
        if (en1)      n = GRP_ALT_ONE;
        else if (en2) n = GRP_ALT_TWO;
      end
      GRP_ALT_ONE: begin
        if (en2)      n = GRP_ALT_TWO;
      end
      default:        n = GRP_PRIMARY;
    endcase
    return n;
  endfunction : nextGroup

  group_t state_q;
  group_t state_d;
  logic   advPrev_q;
  logic   selHeld_q;
  logic   loaded_q;
  logic   saved_q;

  wire logic sel1     = grp.altOneSel & grp.altOneEn;
  wire logic sel2     = grp.altTwoSel & grp.altTwoEn;
  wire logic selHeld  = sel1 | sel2;
  wire logic advEdge  = grp.advance & ~advPrev_q;
  wire logic curValid = (state_q == GRP_PRIMARY) ||
                        (state_q == GRP_ALT_ONE && grp.altOneEn) ||
                        (state_q == GRP_ALT_TWO && grp.altTwoEn);

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (!loaded_q) begin
      if (grp.restoreValid)
        state_d = grp.restoreGroup;
    end else if (sel2) begin
      state_d = GRP_ALT_TWO;
    end else if (sel1) begin
      state_d = GRP_ALT_ONE;
    end else if (selHeld_q) begin
      state_d = GRP_PRIMARY;
    end else if (!curValid) begin
      state_d = GRP_PRIMARY;
    end else if (advEdge) begin
      state_d = nextGroup(state_q, grp.altOneEn, grp.altTwoEn);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= GRP_PRIMARY;
      advPrev_q <= 1'b1;
      selHeld_q <= 1'b0;
      loaded_q  <= 1'b0;
      saved_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      advPrev_q <= grp.advance;
      selHeld_q <= loaded_q & selHeld;
      loaded_q  <= 1'b1;
      saved_q   <= loaded_q && (state_d != state_q);
    end
  end

  assign grp.active     = state_q;
  // Delayed one cycle so the store strobe lines up with the new group
  assign grp.saveStrobe = saved_q;

endmodule : group_sequencer

/* File: settings_group_selector.sv */
// Pushbutton control and settings group selector with AHB-Lite registers
`include "settings_group_map.svh"

module settings_group_selector
  import settings_group_pkg::*;
(
  input  wire logic        clk,              // System clock
  input  wire logic        reset_n,          // Async reset, active low
  // AHB-Lite slave
  input  wire logic        hsel,             // Slave select
  input  wire logic [31:0] haddr,            // Address
  input  wire logic [1:0]  htrans,           // Transfer type
  input  wire logic        hwrite,           // Write
  input  wire logic [2:0]  hsize,            // Transfer size
  input  wire logic        hready,           // Bus ready in
  input  wire logic [31:0] hwdata,           // Write data
  output      logic [31:0] hrdata,           // Read data
  output      logic        hreadyout,        // Slave ready
  output      logic        hresp,            // Response, always OKAY
  // Operator panel and logic inputs
  input  wire logic [5:0]  panelPress,       // Panel button levels
  input  wire logic        remoteLockout,    // Reject remote commands
  input  wire logic        groupAdvance,     // Group advance input
  input  wire logic        altOneSelect,     // Alternate one select
  input  wire logic        altTwoSelect,     // Alternate two select
  // Non-volatile group store
  input  wire logic        storedValid,      // Stored group valid
  input  wire logic [2:0]  storedGroup,      // Stored group, one-hot
  output      logic        saveStrobe,       // Write store, one pulse
  output      logic [2:0]  saveGroup,        // Group to store
  // Outputs
  output      logic [5:0]  pushbuttonOut,    // Pushbutton outputs
  output      logic        primaryActive,    // Primary group active
  output      logic        altOneActive,     // Alternate one active
  output      logic        altTwoActive      // Alternate two active
);

  // --------------------------------------------------------------------
  // Byte offset decode
  // --------------------------------------------------------------------
  function automatic logic isReg(input logic [31:0] a,
                                 input logic [7:0]  off);
    return (a[31:8] == 24'h00_0000) && (a[7:0] == off);
  endfunction : isReg

  // --------------------------------------------------------------------
  // Bus slave, zero wait states
  // --------------------------------------------------------------------
  logic        wrPend_q;
  logic [7:0]  wrAddr_q;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;

  wire logic addrPhase = hsel & hready & htrans[1];
  wire logic wrAccept  = addrPhase & hwrite;
  wire logic rdAccept  = addrPhase & ~hwrite;

  wire logic wrConfig  = wrPend_q && (wrAddr_q == `SG_PB_CONFIG_OFFSET);
  wire logic wrRemote  = wrPend_q && (wrAddr_q == `SG_PB_REMOTE_OFFSET);
  wire logic wrGroup   = wrPend_q && (wrAddr_q == `SG_GROUP_CFG_OFFSET);

  logic        mapped;

  assign mapped = isReg(haddr, `SG_PB_CONFIG_OFFSET) ||
                  isReg(haddr, `SG_PB_REMOTE_OFFSET) ||
                  isReg(haddr, `SG_GROUP_CFG_OFFSET) ||
                  isReg(haddr, `SG_GROUP_STAT_OFFSET);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= wrAccept & mapped;
      wrAddr_q <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  logic [5:0] pbEnable_q;
  logic [5:0] pbMaint_q;
  logic [1:0] altEn_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pbEnable_q <= `SG_PB_ENABLE_RESET;
      pbMaint_q  <= `SG_PB_MAINT_RESET;
      altEn_q    <= `SG_ALT_EN_RESET;
    end else begin
      if (wrConfig) begin
        pbEnable_q <= hwdata[`SG_PB_ENABLE_LSB +: 6];
        pbMaint_q  <= hwdata[`SG_PB_MAINT_LSB +: 6];
      end
      if (wrGroup) begin
        altEn_q[0] <= hwdata[`SG_ALT_ONE_SELECT_INPUT_EN_BIT];
        altEn_q[1] <= hwdata[`SG_ALT_TWO_SELECT_INPUT_EN_BIT];
      end
    end
  end

  // --------------------------------------------------------------------
  // Pushbuttons
  // --------------------------------------------------------------------
  logic [5:0] panelPrev_q;
  logic [5:0] maintState_q;
  logic [5:0] pbOut_q;
  logic [5:0] pbOut_d;
  logic [5:0] maintState_d;

  wire logic [5:0] panelEdge   = panelPress & ~panelPrev_q;
  wire logic [5:0] panelPush   = panelEdge & pbEnable_q;
  wire logic [5:0] remotePush  = (wrRemote && !remoteLockout) ?
                                 hwdata[5:0] : 6'h00;
  wire logic [5:0] press       = panelPush | remotePush;

  always_comb begin
    maintState_d = maintState_q;
    pbOut_d      = 6'h00;
    for (int i = 0; i < `SG_PB_COUNT; i++) begin
      if (pbMaint_q[i]) begin
        if (press[i])
          maintState_d[i] = ~maintState_q[i];
        pbOut_d[i] = maintState_d[i];
      end else begin
        maintState_d[i] = 1'b0;
        pbOut_d[i]      = press[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      panelPrev_q  <= 6'h3F;
      maintState_q <= 6'h00;
      pbOut_q      <= 6'h00;
    end else begin
      panelPrev_q  <= panelPress;
      maintState_q <= maintState_d;
      pbOut_q      <= pbOut_d;
    end
  end

  assign pushbuttonOut = pbOut_q;

  // --------------------------------------------------------------------
  // Settings group sequencer
  // --------------------------------------------------------------------
  group_if grp ();

  assign grp.advance      = groupAdvance;
  assign grp.altOneSel    = altOneSelect;
  assign grp.altTwoSel    = altTwoSelect;
  assign grp.altOneEn     = altEn_q[0];
  assign grp.altTwoEn     = altEn_q[1];
  assign grp.restoreValid = storedValid &&
                            (storedGroup == GRP_PRIMARY ||
                             storedGroup == GRP_ALT_ONE ||
                             storedGroup == GRP_ALT_TWO);
  assign grp.restoreGroup = group_t'(storedGroup);

  group_sequencer u_seq (
    .clk     (clk),
    .reset_n (reset_n),
    .grp     (grp.seq)
  );

  logic [2:0] active_q;
  logic       save_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      save_q   <= 1'b0;
      active_q <= GRP_PRIMARY;
    end else begin
      save_q   <= grp.saveStrobe;
      active_q <= grp.active;
    end
  end

  assign saveStrobe    = save_q;
  assign saveGroup     = active_q;
  assign primaryActive = active_q[0];
  assign altOneActive  = active_q[1];
  assign altTwoActive  = active_q[2];

  // --------------------------------------------------------------------
  // Read data, captured in the address phase
  // --------------------------------------------------------------------
  wire logic [31:0] cfgWord  = {18'h0_0000, pbMaint_q, 2'b00, pbEnable_q};
  wire logic [31:0] outWord  = {26'h000_0000, pbOut_q};
  wire logic [31:0] grpWord  = {30'h0000_0000, altEn_q};
  wire logic [31:0] statWord = {25'h000_0000, remoteLockout,
                                altTwoSelect, altOneSelect,
                                1'b0, active_q};

  always_comb begin
    if (isReg(haddr, `SG_PB_CONFIG_OFFSET))
      rdData_d = cfgWord;
    else if (isReg(haddr, `SG_PB_REMOTE_OFFSET))
      rdData_d = outWord;
    else if (isReg(haddr, `SG_GROUP_CFG_OFFSET))
      rdData_d = grpWord;
    else if (isReg(haddr, `SG_GROUP_STAT_OFFSET))
      rdData_d = statWord;
    else
      rdData_d = 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      rdData_q <= 32'h0000_0000;
    else if (rdAccept)
      rdData_q <= rdData_d;
  end

  assign hrdata = rdData_q;

endmodule : settings_group_selector

/* File: settings_group_selector_sva.sv */
// Port assertions for the group selector
`include "settings_group_map.svh"
module settings_group_selector_sva
  import settings_group_pkg::*;
(
  input wire logic        clk,           // Clock
  input wire logic        reset_n,       // Reset, active low
  input wire logic        hsel,          // Select
  input wire logic [31:0] haddr,         // Address
  input wire logic [1:0]  htrans,        // Transfer type
  input wire logic        hwrite,        // Write
  input wire logic        hready,        // Ready in
  input wire logic [31:0] hwdata,        // Write data
  input wire logic        hreadyout,     // Ready out
  input wire logic        hresp,         // Response
  input wire logic        groupAdvance,  // Advance
  input wire logic        altOneSelect,  // Alt one select
  input wire logic        altTwoSelect,  // Alt two select
  input wire logic        saveStrobe,    // Store strobe
  input wire logic [2:0]  saveGroup,     // Store group
  input wire logic        primaryActive, // Primary active
  input wire logic        altOneActive,  // Alt one active
  input wire logic        altTwoActive   // Alt two active
);
  logic [2:0] act;
  logic [1:0] altEn_q;
  logic [1:0] upCnt_q;
  logic       wrPend_q;
  logic [7:0] wrAddr_q;
  logic       ready;
  assign act = {altTwoActive, altOneActive, primaryActive};
  assign ready = (upCnt_q == 2'h3);
  // Mirror of the group enable register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      altEn_q  <= `SG_ALT_EN_RESET;
      upCnt_q  <= 2'h0;
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      if (upCnt_q != 2'h3)
        upCnt_q <= upCnt_q + 2'h1;
      wrPend_q <= hsel && hready && htrans[1] && hwrite;
      wrAddr_q <= haddr[7:0];
      if (wrPend_q && wrAddr_q == `SG_GROUP_CFG_OFFSET)
        altEn_q <= hwdata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence quietSel;
    !altOneSelect && !altTwoSelect && !$past(altOneSelect)
      && !$past(altTwoSelect);
  endsequence
  sequence advRise;
    $rose(groupAdvance) ##0 quietSel;
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  chk_one_hot_group: assert property ($onehot(act))
    else $error("active group not one-hot");
  chk_alt_two_wins: assert property (
    ready && altTwoSelect && altEn_q[1] |-> ##2 altTwoActive)
    else $error("alt two select not obeyed");
  chk_alt_one_sel: assert property (
    ready && altOneSelect && altEn_q[0] && !(altTwoSelect && altEn_q[1])
    |-> ##2 altOneActive)
    else $error("alt one select not obeyed");
  chk_alts_off: assert property (
    ready && altEn_q == 2'h0 |-> ##2 primaryActive)
    else $error("primary not active with alternates off");
  chk_adv_step: assert property (
    (ready && altEn_q == 2'h3) ##0 advRise
    |-> ##2 act == {$past(act[1:0]), $past(act[2])})
    else $error("advance did not move to next group");
  chk_adv_held: assert property (
    (ready && groupAdvance && $past(groupAdvance) && !wrPend_q
      && !$past(wrPend_q)) ##0 quietSel |-> ##2 $stable(act))
    else $error("held advance moved the group");
  chk_save_follow: assert property (
    ready && $changed(act) |-> saveStrobe && saveGroup == act)
    else $error("group change not saved");
endmodule : settings_group_selector_sva

bind settings_group_selector settings_group_selector_sva chk_u (
  .clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hreadyout, .hresp, .groupAdvance, .altOneSelect, .altTwoSelect,
  .saveStrobe, .saveGroup, .primaryActive, .altOneActive, .altTwoActive);

/* File: nv_store_model.sv */
// Non-volatile group store that survives control power cycling
module nv_store_model
  import settings_group_pkg::*;
(
  input  wire logic       clk,         // Clock
  input  wire logic       saveStrobe,  // Store strobe
  input  wire logic [2:0] saveGroup,   // Group to keep
  output      logic       storedValid, // Content valid
  output      logic [2:0] storedGroup  // Kept group
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    storedValid = 1'b0;
    storedGroup = 3'b000;
  end
  // Kept across device reset
  always @(posedge clk) begin
    if (saveStrobe) begin
      storedValid <= 1'b1;
      storedGroup <= saveGroup;
    end
  end
endmodule : nv_store_model

/* File: testbench.sv */
// Self-checking bench for the group selector
`include "settings_group_map.svh"
module testbench
  import settings_group_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, storedGroup, saveGroup;
  logic [5:0]  panelPress, pushbuttonOut;
  logic        remoteLockout, groupAdvance, altOneSelect, altTwoSelect;
  logic        storedValid, saveStrobe;
  logic        primaryActive, altOneActive, altTwoActive;
  int          n_fail, n_checks, cnt;
  settings_group_selector dut_u (.clk, .reset_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
    .hresp, .panelPress, .remoteLockout, .groupAdvance, .altOneSelect,
    .altTwoSelect, .storedValid, .storedGroup, .saveStrobe, .saveGroup,
    .pushbuttonOut, .primaryActive, .altOneActive, .altTwoActive);
  nv_store_model nv_u (.clk, .saveStrobe, .saveGroup, .storedValid,
    .storedGroup);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic close_out;
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_fail++;
        close_out();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= AHB_NONSEQ;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= AHB_IDLE;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    tick(2);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk32(r, exp);
  endtask : rd_chk
  task automatic adv_chk(input int len, input logic [31:0] exp);
    groupAdvance <= 1'b1;
    tick(len);
    groupAdvance <= 1'b0;
    tick(3);
    rd_chk(`SG_GROUP_STAT_OFFSET, exp);
    chk32({29'h0, altTwoActive, altOneActive, primaryActive},
          exp & 32'h0000_0007);
  endtask : adv_chk
  task automatic press(input int b);
    panelPress[b] <= 1'b1;
    tick(2);
    panelPress[b] <= 1'b0;
    tick(3);
  endtask : press
  initial begin
    tick(20000);
    n_fail++;
    close_out();
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    {panelPress, remoteLockout, groupAdvance} = '0;
    {altOneSelect, altTwoSelect} = '0;
    reset_n = 1'b0;
    tick(10);
    reset_n <= 1'b1;
    tick(3);
    rd_chk(`SG_PB_CONFIG_OFFSET, 32'h0000_3F00);
    rd_chk(`SG_GROUP_CFG_OFFSET, 32'h0000_0003);
    rd_chk(`SG_GROUP_STAT_OFFSET, 32'h0000_0001);
    rd_chk(8'h10, 32'h0000_0000);
    adv_chk(1, 32'h0000_0002);
    adv_chk(1, 32'h0000_0004);
    adv_chk(1, 32'h0000_0001);
    adv_chk(20, 32'h0000_0002);
    wr(`SG_GROUP_CFG_OFFSET, 32'h0000_0001);
    adv_chk(1, 32'h0000_0001);
    wr(`SG_GROUP_CFG_OFFSET, 32'h0000_0002);
    adv_chk(1, 32'h0000_0004);
    wr(`SG_GROUP_CFG_OFFSET, 32'h0000_0000);
    rd_chk(`SG_GROUP_STAT_OFFSET, 32'h0000_0001);
    adv_chk(1, 32'h0000_0001);
    wr(`SG_GROUP_CFG_OFFSET, 32'h0000_0003);
    altOneSelect <= 1'b1;
    tick(3);
    rd_chk(`SG_GROUP_STAT_OFFSET, 32'h0000_0012);
    altTwoSelect <= 1'b1;
    tick(3);
    rd_chk(`SG_GROUP_STAT_OFFSET, 32'h0000_0034);
    adv_chk(1, 32'h0000_0034);
    altOneSelect <= 1'b0;
    altTwoSelect <= 1'b0;
    tick(3);
    rd_chk(`SG_GROUP_STAT_OFFSET, 32'h0000_0001);
    wr(`SG_PB_CONFIG_OFFSET, 32'h0000_0F3F);
    press(0);
    rd_chk(`SG_PB_REMOTE_OFFSET, 32'h0000_0001);
    press(0);
    rd_chk(`SG_PB_REMOTE_OFFSET, 32'h0000_0000);
    panelPress[4] <= 1'b1;
    cnt = 0;
    repeat (6) begin
      @(negedge clk);
      if (pushbuttonOut[4] === 1'b1)
        cnt++;
    end
    @(posedge clk);
    panelPress[4] <= 1'b0;
    chk32(32'(cnt), 32'h0000_0001);
    wr(`SG_PB_CONFIG_OFFSET, 32'h0000_0F00);
    press(1);
    rd_chk(`SG_PB_REMOTE_OFFSET, 32'h0000_0000);
    wr(`SG_PB_REMOTE_OFFSET, 32'h0000_0002);
    rd_chk(`SG_PB_REMOTE_OFFSET, 32'h0000_0002);
    remoteLockout <= 1'b1;
    wr(`SG_PB_REMOTE_OFFSET, 32'h0000_0002);
    rd_chk(`SG_PB_REMOTE_OFFSET, 32'h0000_0002);
    rd_chk(`SG_GROUP_STAT_OFFSET, 32'h0000_0041);
    remoteLockout <= 1'b0;
    wr(`SG_PB_REMOTE_OFFSET, 32'h0000_0002);
    rd_chk(`SG_PB_REMOTE_OFFSET, 32'h0000_0000);
    adv_chk(1, 32'h0000_0002);
    reset_n <= 1'b0;
    tick(3);
    reset_n <= 1'b1;
    tick(4);
    rd_chk(`SG_GROUP_STAT_OFFSET, 32'h0000_0002);
    close_out();
  end
endmodule : testbench
